// file: rtl/sscc_pkg.sv
// Purpose: shared constants, types and crc helpers of the spi command link
// Assumes: one system clock for both ends
// Notes:   crc is the serial, augmented form shifted in at the lsb
package sscc_pkg;

    // ****************************************************************
    // frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 32;
    localparam int CRC_BITS   = 8;
    localparam int MSG_BITS   = FRAME_BITS - CRC_BITS;
    localparam int CMD_MSB    = 31;
    localparam int CMD_LSB    = 28;
    localparam int SF_MSB     = 9;
    localparam int SF_LSB     = 8;
    localparam int SRC_CNT    = 8;
    localparam int SENS_W     = 16;
    localparam int CNT_W      = 6;

    localparam logic [3:0] CMD_REG_WRITE = 4'h8;
    localparam logic [3:0] CMD_REG_READ  = 4'hc;
    localparam logic [1:0] ST_ERROR      = 2'h3;
    localparam logic [1:0] SF_SPI_ERR    = 2'h3;
    localparam logic [15:0] SENS_ZERO    = 16'h0000;
    localparam logic [19:0] RSVD_FILL    = 20'h00000;
    localparam logic [5:0] CNT_MAX       = 6'h3f;
    localparam logic [2:0] PIN_IDLE      = 3'h4;

    // ****************************************************************
    // crc
    // ****************************************************************
    localparam logic [7:0] CRC_POLY  = 8'h2f;
    localparam logic [3:0] SEED_HI   = 4'hf;
    localparam logic [3:0] SEED_ZERO = 4'h0;

    // ****************************************************************
    // host register map and fields
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_RESP     = 8'h08;
    localparam logic [7:0] OFS_STAT     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam int CTRL_START  = 0;
    localparam int CTRL_SEED_L = 4;
    localparam int IRQ_W       = 3;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_CRC_ERR = 1;
    localparam int IRQ_SPI_ERR = 2;
    localparam int HALF_CYC    = 8;

    typedef enum {KIND_DATA, KIND_RSVD, KIND_ERR} sscc_kind_t;
    typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TRAIL, H_GAP}
        sscc_hstate_t;

    function automatic logic [7:0] seed_of(input logic [3:0] nib);
        return (nib == SEED_ZERO) ? {SEED_HI, SEED_HI} : {SEED_HI, nib};
    endfunction

    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic       d);
        return {c[6:0], d} ^ (c[7] ? CRC_POLY : 8'h00);
    endfunction

    // crc over the 24 message bits followed by eight zeros
    function automatic logic [7:0] crc_of(input logic [7:0]  seed,
                                          input logic [23:0] msg);
        logic [7:0] c;
        c = seed;
        for (int i = MSG_BITS - 1; i >= 0; i--) begin
            c = crc_step(c, msg[i]);
        end
        for (int i = 0; i < CRC_BITS; i++) begin
            c = crc_step(c, 1'b0);
        end
        return c;
    endfunction

endpackage

// file: rtl/sscc_spi_if.sv
// Purpose: four-wire spi link between host controller and sensor end
// Assumes: host owns chip select, serial clock and command data
// Notes:   every wire has exactly one driver, no tristate
`timescale 1ns/10ps
interface sscc_spi_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;

    modport dev  (input csN, input sclk, input mosi, output miso);
    modport host (output csN, output sclk, output mosi, input miso);
endinterface // sscc_spi_if

// file: rtl/sscc_dev.sv
// Purpose: sensor end of the spi command layer, 32-bit frames
// Assumes: spi mode 0, pins sampled on the system clock
// Notes:   answer to a frame goes out during the next frame
//
// Functional notes
// - data request: lsb one, middle bits zero
// - upper command bits select source, echoed back
// - response: echo, status, value, detail, crc
// - other even non-register codes are reserved, crc-checked
// - reserved command answered in the next frame
// - reserved answer fields undefined, crc still valid
// - crc over all 32 command bits, msb first
// - crc mismatch: drop command, send error response
// - preload seed, shift bits in at lsb
// - zero residue good, nonzero residue fails
// - polynomial x8+x5+x3+x2+x+1 for every seed
// - seed all ones, or ones over nonzero nibble
// - value captured at frame's falling chip select
// - response crc: 24 bits then eight zeros
// - basic status sampled at previous rising select
`timescale 1ns/10ps
module sscc_dev #(
    parameter int SRC_CNT = sscc_pkg::SRC_CNT,
    parameter int SENS_W  = sscc_pkg::SENS_W
) (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    sscc_spi_if.dev                             spi,
    input  wire logic [SRC_CNT-1:0][SENS_W-1:0] sensorData,
    input  wire logic [1:0]                     basicStatusField,
    input  wire logic [1:0]                     detailedStatusField,
    input  wire logic [3:0]                     crcSeedNibble,
    output logic                                cmdAccepted,
    output logic                                crcFail,
    output logic                                frameError,
    output logic [2:0]                          sourceSelectCode
);

    // ****************************************************************
    // pin synchronisers and edge detect
    // ****************************************************************
    logic [2:0]          syncA_ff;
    logic [2:0]          syncB_ff;
    logic [2:0]          prev_ff;
    logic                csLvl;
    logic                sclkLvl;
    logic                mosiLvl;
    logic                csFall;
    logic                csRise;
    logic                sclkRise;
    logic                sclkFall;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA_ff <= sscc_pkg::PIN_IDLE;
            syncB_ff <= sscc_pkg::PIN_IDLE;
            prev_ff  <= sscc_pkg::PIN_IDLE;
        end else begin
            syncA_ff <= {spi.csN, spi.sclk, spi.mosi};
            syncB_ff <= syncA_ff;
            prev_ff  <= syncB_ff;
        end
    end

    assign csLvl    = syncB_ff[2];
    assign sclkLvl  = syncB_ff[1];
    assign mosiLvl  = syncB_ff[0];
    assign csFall   = prev_ff[2] & ~csLvl;
    assign csRise   = ~prev_ff[2] & csLvl;
    assign sclkRise = ~csLvl & ~prev_ff[1] & sclkLvl;
    assign sclkFall = ~csLvl & prev_ff[1] & ~sclkLvl;

    // ****************************************************************
    // receive shift register, bit count and crc check
    // ****************************************************************
    logic [31:0]         rxShift_ff;
    logic [5:0]          bitCnt_ff;
    logic [7:0]          crc_ff;
    logic                edgeErr_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxShift_ff <= '0;
        end else if (sclkRise) begin
            rxShift_ff <= {rxShift_ff[30:0], mosiLvl};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_ff <= '0;
        end else if (csFall) begin
            bitCnt_ff <= '0;
        end else if (sclkRise && bitCnt_ff != sscc_pkg::CNT_MAX) begin
            bitCnt_ff <= bitCnt_ff + 6'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            crc_ff <= '0;
        end else if (csFall) begin
            crc_ff <= sscc_pkg::seed_of(crcSeedNibble);
        end else if (sclkRise) begin
            crc_ff <= sscc_pkg::crc_step(crc_ff, mosiLvl);
        end
    end

    // clock high at either select edge spoils the frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            edgeErr_ff <= 1'b0;
        end else if (csFall) begin
            edgeErr_ff <= sclkLvl;
        end else if (csRise && sclkLvl) begin
            edgeErr_ff <= 1'b1;
        end
    end

    // ****************************************************************
    // frame end: classify the command
    // ****************************************************************
    logic [3:0]          cmdNib;
    logic                lenOk;
    logic                crcOk;
    logic                frameOk;
    logic                isRegCmd;
    sscc_pkg::sscc_kind_t nxt_kind;

    assign cmdNib   = rxShift_ff[sscc_pkg::CMD_MSB:sscc_pkg::CMD_LSB];
    assign lenOk    = bitCnt_ff == 6'(sscc_pkg::FRAME_BITS);
    assign crcOk    = crc_ff == 8'h00;
    assign frameOk  = lenOk & crcOk & ~edgeErr_ff & ~sclkLvl;
    assign isRegCmd = (cmdNib == sscc_pkg::CMD_REG_WRITE) ||
                      (cmdNib == sscc_pkg::CMD_REG_READ);

    always_comb begin
        if (!frameOk) begin
            nxt_kind = sscc_pkg::KIND_ERR;
        end else if (cmdNib[0]) begin
            nxt_kind = sscc_pkg::KIND_DATA;
        end else if (isRegCmd) begin
            // register access is not served by this end
            nxt_kind = sscc_pkg::KIND_ERR;
        end else begin
            nxt_kind = sscc_pkg::KIND_RSVD;
        end
    end

    // ****************************************************************
    // pending answer for the next frame
    // ****************************************************************
    sscc_pkg::sscc_kind_t pendKind_ff;
    logic [3:0]          pendCmd_ff;
    logic [1:0]          pendSt_ff;
    logic [1:0]          pendSf_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pendKind_ff <= sscc_pkg::KIND_ERR;
            pendCmd_ff  <= '0;
        end else if (csRise) begin
            pendKind_ff <= nxt_kind;
            pendCmd_ff  <= cmdNib;
        end
    end

    // status as seen at the rising select of this command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pendSt_ff <= sscc_pkg::ST_ERROR;
            pendSf_ff <= sscc_pkg::SF_SPI_ERR;
        end else if (csRise) begin
            pendSt_ff <= basicStatusField;
            pendSf_ff <= detailedStatusField;
        end
    end

    // ****************************************************************
    // events and source select
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmdAccepted <= 1'b0;
            crcFail     <= 1'b0;
            frameError  <= 1'b0;
        end else begin
            cmdAccepted <= csRise & frameOk & ~isRegCmd;
            crcFail     <= csRise & lenOk & ~crcOk;
            frameError  <= csRise & ~frameOk;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sourceSelectCode <= '0;
        end else if (csRise && nxt_kind == sscc_pkg::KIND_DATA) begin
            sourceSelectCode <= cmdNib[3:1];
        end
    end

    // ****************************************************************
    // response assembly at the falling select
    // ****************************************************************
    logic [SENS_W-1:0]   selData;
    logic [23:0]         nxt_body;
    logic [31:0]         txShift_ff;

    // sampled in the cycle the falling select is seen
    assign selData = sensorData[pendCmd_ff[3:1]];

    always_comb begin
        case (pendKind_ff)
            sscc_pkg::KIND_DATA: begin
                nxt_body = {pendCmd_ff, pendSt_ff, selData, pendSf_ff};
            end
            sscc_pkg::KIND_RSVD: begin
                nxt_body = {pendCmd_ff, sscc_pkg::RSVD_FILL};
            end
            default: begin
                nxt_body = {pendCmd_ff, sscc_pkg::ST_ERROR,
                            sscc_pkg::SENS_ZERO, sscc_pkg::SF_SPI_ERR};
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txShift_ff <= '0;
        end else if (csFall) begin
            txShift_ff <= {nxt_body, sscc_pkg::crc_of(
                           sscc_pkg::seed_of(crcSeedNibble), nxt_body)};
        end else if (sclkFall) begin
            txShift_ff <= {txShift_ff[30:0], 1'b0};
        end
    end

    assign spi.miso = txShift_ff[31];

endmodule // sscc_dev

// file: rtl/sscc_host.sv
// Purpose: spi host controller, commands ordered over apb
// Assumes: the sensor end uses the same crc seed nibble
// Notes:   serial clock is the system clock divided by 2*HALF
`timescale 1ns/10ps
module sscc_host #(
    parameter int HALF = sscc_pkg::HALF_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    sscc_spi_if.host         spi,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // ****************************************************************
    // apb registers
    // ****************************************************************
    logic [3:0]                  seed_ff;
    logic [23:0]                 cmdWord_ff;
    logic [31:0]                 respWord_ff;
    logic [sscc_pkg::IRQ_W-1:0]  irqStat_ff;
    logic [sscc_pkg::IRQ_W-1:0]  irqMask_ff;
    logic [sscc_pkg::IRQ_W-1:0]  irqSet;
    logic                        wrEn;
    logic                        mapped;
    logic                        startReq;
    logic                        busy;
    logic [31:0]                 nxt_rd;
    sscc_pkg::sscc_hstate_t      state_ff;

    assign busy   = state_ff != sscc_pkg::H_IDLE;
    assign mapped = paddr inside {sscc_pkg::OFS_CTRL, sscc_pkg::OFS_CMD,
                    sscc_pkg::OFS_RESP, sscc_pkg::OFS_STAT,
                    sscc_pkg::OFS_IRQ_STAT, sscc_pkg::OFS_IRQ_MASK};
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wrEn    = psel & penable & pwrite & mapped;
    assign startReq = wrEn & (paddr == sscc_pkg::OFS_CTRL) &
                      pwdata[sscc_pkg::CTRL_START] & ~busy;

    always_comb begin
        case (paddr)
            sscc_pkg::OFS_CTRL:     nxt_rd = {24'h0, seed_ff, 4'h0};
            sscc_pkg::OFS_CMD:      nxt_rd = {cmdWord_ff, 8'h00};
            sscc_pkg::OFS_RESP:     nxt_rd = respWord_ff;
            sscc_pkg::OFS_STAT:     nxt_rd = {31'h0, busy};
            sscc_pkg::OFS_IRQ_STAT: nxt_rd = {29'h0, irqStat_ff};
            sscc_pkg::OFS_IRQ_MASK: nxt_rd = {29'h0, irqMask_ff};
            default:                nxt_rd = 32'h0;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= nxt_rd;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seed_ff    <= '0;
            cmdWord_ff <= '0;
            irqMask_ff <= '0;
        end else if (wrEn) begin
            if (paddr == sscc_pkg::OFS_CTRL) begin
                seed_ff <= pwdata[sscc_pkg::CTRL_SEED_L +: 4];
            end
            if (paddr == sscc_pkg::OFS_CMD) begin
                cmdWord_ff <= pwdata[31:8];
            end
            if (paddr == sscc_pkg::OFS_IRQ_MASK) begin
                irqMask_ff <= pwdata[sscc_pkg::IRQ_W-1:0];
            end
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_ff <= '0;
        end else if (wrEn && paddr == sscc_pkg::OFS_IRQ_STAT) begin
            irqStat_ff <= (irqStat_ff & ~pwdata[sscc_pkg::IRQ_W-1:0]) |
                          irqSet;
        end else begin
            irqStat_ff <= irqStat_ff | irqSet;
        end
    end

    assign irq = |(irqStat_ff & irqMask_ff);

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    logic [1:0]   misoSync_ff;
    logic [15:0]  cnt_ff;
    logic [5:0]   bits_ff;
    logic [31:0]  txWord_ff;
    logic [31:0]  rxWord_ff;
    logic         phaseEnd;

    assign phaseEnd = cnt_ff == 16'(HALF - 1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            misoSync_ff <= '0;
        end else begin
            misoSync_ff <= {misoSync_ff[0], spi.miso};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (startReq || phaseEnd) begin
            cnt_ff <= '0;
        end else if (busy) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= sscc_pkg::H_IDLE;
        end else begin
            case (state_ff)
                sscc_pkg::H_IDLE: begin
                    if (startReq) state_ff <= sscc_pkg::H_LEAD;
                end
                sscc_pkg::H_LEAD, sscc_pkg::H_LOW: begin
                    if (phaseEnd) state_ff <= sscc_pkg::H_HIGH;
                end
                sscc_pkg::H_HIGH: begin
                    if (phaseEnd) begin
                        state_ff <= (bits_ff == 6'(sscc_pkg::FRAME_BITS))
                                    ? sscc_pkg::H_TRAIL : sscc_pkg::H_LOW;
                    end
                end
                sscc_pkg::H_TRAIL: begin
                    if (phaseEnd) state_ff <= sscc_pkg::H_GAP;
                end
                sscc_pkg::H_GAP: begin
                    if (phaseEnd) state_ff <= sscc_pkg::H_IDLE;
                end
                default: state_ff <= sscc_pkg::H_IDLE;
            endcase
        end
    end

    // sample on the way up, shift out on the way down
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bits_ff   <= '0;
            txWord_ff <= '0;
            rxWord_ff <= '0;
        end else if (startReq) begin
            bits_ff   <= '0;
            txWord_ff <= {cmdWord_ff, sscc_pkg::crc_of(sscc_pkg::seed_of(
                          pwdata[sscc_pkg::CTRL_SEED_L +: 4]), cmdWord_ff)};
        end else if (phaseEnd && (state_ff == sscc_pkg::H_LEAD ||
                                  state_ff == sscc_pkg::H_LOW)) begin
            bits_ff   <= bits_ff + 6'h01;
            rxWord_ff <= {rxWord_ff[30:0], misoSync_ff[1]};
        end else if (phaseEnd && state_ff == sscc_pkg::H_HIGH) begin
            txWord_ff <= {txWord_ff[30:0], 1'b0};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            respWord_ff <= '0;
        end else if (phaseEnd && state_ff == sscc_pkg::H_GAP) begin
            respWord_ff <= rxWord_ff;
        end
    end

    always_comb begin
        irqSet = '0;
        if (phaseEnd && state_ff == sscc_pkg::H_GAP) begin
            irqSet[sscc_pkg::IRQ_DONE] = 1'b1;
            irqSet[sscc_pkg::IRQ_CRC_ERR] = rxWord_ff[7:0] !=
                sscc_pkg::crc_of(sscc_pkg::seed_of(seed_ff),
                                 rxWord_ff[31:8]);
            irqSet[sscc_pkg::IRQ_SPI_ERR] =
                rxWord_ff[sscc_pkg::SF_MSB:sscc_pkg::SF_LSB] ==
                sscc_pkg::SF_SPI_ERR;
        end
    end

    assign spi.csN  = ~(busy && state_ff != sscc_pkg::H_GAP);
    assign spi.sclk = state_ff == sscc_pkg::H_HIGH;
    assign spi.mosi = txWord_ff[31];

endmodule // sscc_host

// file: tb/sscc_monitor.sv
// Purpose: wire checks on the spi link between host and sensor end
// Assumes: half bit period of 8 clocks
// Notes:   frame bits collected at each serial clock rise
`timescale 1ns/10ps
module sscc_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    logic        sclkD_ff;
    logic [5:0]  cnt_ff;
    logic [31:0] moSh_ff;
    logic [31:0] miSh_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclkD_ff <= 1'b0;
            cnt_ff   <= 6'h00;
            moSh_ff  <= 32'h0;
            miSh_ff  <= 32'h0;
        end else begin
            sclkD_ff <= sclk;
            if (!csN && sclk && !sclkD_ff) begin
                cnt_ff  <= cnt_ff + 6'h01;
                moSh_ff <= {moSh_ff[30:0], mosi};
                miSh_ff <= {miSh_ff[30:0], miso};
            end else if (csN) begin
                cnt_ff <= 6'h00;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence lead_s;
        (!sclk) [*8];
    endsequence
    sequence high_s;
        sclk [*8] ##1 !sclk;
    endsequence

    idle_clk_a: assert property (csN |-> !sclk)
        else $error("serial clock high outside frame");
    lead_low_a: assert property ($fell(csN) |-> lead_s)
        else $error("lead phase too short");
    high_len_a: assert property ($rose(sclk) |-> high_s)
        else $error("serial clock high phase length");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("command bit moved while clock high");
    miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso))
        else $error("response bit moved while clock high");
    bit_count_a: assert property ($rose(csN) |-> cnt_ff == 6'h20)
        else $error("frame not 32 bits");
    gap_min_a: assert property ($rose(csN) |-> csN [*8])
        else $error("select gap too short");
    fixed_zero_a: assert property ($rose(csN) && moSh_ff[28] |->
        moSh_ff[27:8] == 20'h0) else $error("request fixed bits set");
    rsvd_data_a: assert property ($rose(csN) && !miSh_ff[28] &&
        miSh_ff[9:8] != 2'h3 |-> miSh_ff[27:8] == 20'h0)
        else $error("reserved answer data not zero");
endmodule // sscc_monitor

// file: tb/spi_sensor_cmd_crc_check_tb.sv
// Purpose: host and sensor end joined, driven over apb
// Assumes: each frame carries the answer to the previous one
// Notes:   expected answers built from a bench-side crc
`timescale 1ns/10ps
module spi_sensor_cmd_crc_check_tb;
    localparam logic [3:0] RSVD [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
    logic             clock = 1'b0;
    logic             rst_n = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]      pwdata = 32'h0, prdata, expPrev;
    logic             pready, pslverr, irq, cmdAccepted, crcFail, frameError;
    logic [2:0]       sourceSelectCode;
    logic [7:0][15:0] sens = 128'h9e7f_0a31_77c2_5b04_e6d9_1f28_c3b5_480a;
    logic [1:0]       bs = 2'h1, sf = 2'h0;
    logic [3:0]       devSeed = 4'h0, hostSeed = 4'h0;
    logic             expOk = 1'b0, sawFail = 1'b0;
    int               num_errors = 0, total_checks = 0, cyc = 0, nEv = 0;

    sscc_spi_if sscc_spi_if_i ();
    sscc_host #(.HALF(8)) sscc_host_i (.clock(clock), .rst_n(rst_n),
        .spi(sscc_spi_if_i.host), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    sscc_dev sscc_dev_i (.clock(clock), .rst_n(rst_n),
        .spi(sscc_spi_if_i.dev), .sensorData(sens), .basicStatusField(bs),
        .detailedStatusField(sf), .crcSeedNibble(devSeed),
        .cmdAccepted(cmdAccepted), .crcFail(crcFail),
        .frameError(frameError), .sourceSelectCode(sourceSelectCode));
    sscc_monitor sscc_monitor_i (.clock(clock), .rst_n(rst_n),
        .csN(sscc_spi_if_i.csN), .sclk(sscc_spi_if_i.sclk),
        .mosi(sscc_spi_if_i.mosi), .miso(sscc_spi_if_i.miso));

    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (crcFail === 1'b1) sawFail <= 1'b1;
        nEv += {frameError === 1'b1, 7'h0, cmdAccepted === 1'b1};
        if (cyc == 60000) begin
            num_errors++;
            summarize();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] withCrc(input logic [3:0] s,
                                            input logic [23:0] m);
        logic [7:0]  c;
        logic [31:0] v;
        c = (s == 4'h0) ? 8'hff : {4'hf, s};
        v = {m, 8'h00};
        for (int i = 31; i >= 0; i--) c = {c[6:0], v[i]} ^ (c[7] ? 8'h2f : 8'h00);
        return {m, c};
    endfunction
    function automatic logic [31:0] expResp(input logic [3:0] n, input logic ok);
        if (!ok || n == 4'h8 || n == 4'hc) return withCrc(devSeed, {n, 20'hc0003});
        if (n[0]) return withCrc(devSeed, {n, bs, sens[n[3:1]], sf});
        return withCrc(devSeed, {n, 20'h00000});
    endfunction
    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            num_errors++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task step(input logic [3:0] n, input logic ok);
        logic [31:0] r, st;
        logic        e;
        apb(1'b1, sscc_pkg::OFS_CMD, {n, 28'h0}, r, e);
        apb(1'b1, sscc_pkg::OFS_CTRL, {24'h0, hostSeed, 4'h1}, r, e);
        st = 32'h1;
        while (st[0] !== 1'b0) apb(1'b0, sscc_pkg::OFS_STAT, 32'h0, st, e);
        apb(1'b0, sscc_pkg::OFS_RESP, 32'h0, r, e);
        if (expOk) check("response", r, expPrev);
        expPrev = expResp(n, ok);
        expOk = 1'b1;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_data;
        for (int i = 0; i < 8; i++) begin
            bs <= i[1:0];
            sf <= i[2:1];
            step({i[2:0], 1'b1}, 1'b1);
        end
        step(4'h0, 1'b1);
        check("source", {29'h0, sourceSelectCode}, 32'h7);
        $display("data requests done");
    endtask
    task t_rsvd;
        for (int k = 0; k < 6; k++) step(RSVD[k], 1'b1);
        step(4'h8, 1'b1);
        step(4'hc, 1'b1);
        step(4'h1, 1'b1);
        check("no crc fail", {31'h0, sawFail}, 32'h0);
        $display("reserved codes done");
    endtask
    task t_crc;
        hostSeed = 4'h3;
        step(4'h3, 1'b0);
        hostSeed = devSeed;
        step(4'h5, 1'b1);
        check("crc fail", {31'h0, sawFail}, 32'h1);
        check("events", nEv, 32'h111);
        for (int k = 0; k < 2; k++) begin
            devSeed <= k[0] ? 4'ha : 4'h5;
            hostSeed = k[0] ? 4'ha : 4'h5;
            expOk = 1'b0;
            step(4'h3, 1'b1);
            step(4'hb, 1'b1);
        end
        $display("crc and seeds done");
    endtask
    task t_irq;
        logic [31:0] r;
        logic        e;
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b1, sscc_pkg::OFS_IRQ_MASK, 32'h1, r, e);
        apb(1'b1, sscc_pkg::OFS_IRQ_STAT, 32'h7, r, e);
        @(posedge clock);
        check("cleared irq", {31'h0, irq}, 32'h0);
        step(4'h1, 1'b1);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b0, 8'h20, 32'h0, r, e);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        $display("interrupt and map done");
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_data();
        t_rsvd();
        t_crc();
        t_irq();
        summarize();
    end
endmodule // spi_sensor_cmd_crc_check_tb
